// ---- adc_conv_model.sv ----
// Behavioural model of the four converters.
`timescale 1ns/100ps
`default_nettype none
module adc_conv_model (
   input wire logic core_clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic [3:0] conv_start, // Start.
   input wire logic [3:0][7:0] lat, // Cycles per conversion.
   input wire logic [3:0][23:0] raw, // Result.
   input wire logic [3:0] over_in, // Above range.
   input wire logic [3:0] under_in, // Below range.
   output logic [3:0] conv_busy, // Busy.
   output logic [3:0] conv_done, // Done.
   output logic [3:0] conv_over, // Over.
   output logic [3:0] conv_under, // Under.
   output logic [3:0][23:0] conv_data // Word.
);
   logic [3:0][7:0] cnt_q;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         conv_busy[i] = cnt_q[i] != 8'h0;
      end
   end
   // Outside the done pulse the result lines toggle, so stale words never pass as data.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         {cnt_q, conv_done, conv_over, conv_under, conv_data} <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            conv_done[i] <= cnt_q[i] == 8'h1;
            conv_over[i] <= cnt_q[i] == 8'h1 ? over_in[i] : ~conv_over[i];
            conv_under[i] <= cnt_q[i] == 8'h1 ? under_in[i] : ~conv_under[i];
            conv_data[i] <= cnt_q[i] == 8'h1 ? raw[i] : ~conv_data[i];
            cnt_q[i] <= conv_start[i] ? lat[i] : cnt_q[i] - 8'(cnt_q[i] != 8'h0);
         end
      end
   end
endmodule
`default_nettype wire

// ---- adc_trigger_pacing_control.sv ----
// Trigger, pacing and sample buffering control for four converter subsystems.
`timescale 1ns/100ps
`default_nettype none
`include "pacing_consts.svh"
module adc_trigger_pacing_control
   import pacing_pkg::*;
#(
   parameter int unsigned BASE_DIV = `BASE_DIV,
   parameter int unsigned DEPTH = `BUF_DEPTH,
   parameter int unsigned CORE_HZ = `CORE_CLK_HZ
) (
   input wire logic core_clk, // Core clock, 10 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic [`LINE_COUNT-1:0] din_lines, // Digital trigger input pins.
   input wire logic mains_50hz, // High selects the 50 Hz time base.
   input wire logic [`SUB_COUNT-1:0][1:0] trig_src, // Trigger source per subsystem.
   input wire logic [`SUB_COUNT-1:0][2:0] gain_sel, // Gain code per subsystem.
   input wire logic [`SUB_COUNT-1:0][1:0] range_sel, // Input range per subsystem.
   input wire logic [`SUB_COUNT-1:0][2:0] rate_sel, // Rate code, 0 is fastest.
   input wire logic [`SUB_COUNT-1:0] chan0_listed, // Channel zero is in the list.
   input wire logic [`SUB_COUNT-1:0] sw_start, // Software start write, pulse.
   input wire logic [`SUB_COUNT-1:0] sw_stop, // Orderly stop, pulse.
   input wire logic [`SUB_COUNT-1:0] sw_abort, // Abrupt stop, pulse.
   input wire logic [`SUB_COUNT-1:0] single_req, // Single-value request, pulse.
   input wire logic [`SUB_COUNT-1:0] overrun_clr, // Clear overrun flag, pulse.
   input wire logic [`SUB_COUNT-1:0] conv_busy, // Converter busy.
   input wire logic [`SUB_COUNT-1:0] conv_done, // Conversion result valid, pulse.
   input wire logic [`SUB_COUNT-1:0] conv_over, // Result was above range.
   input wire logic [`SUB_COUNT-1:0] conv_under, // Result was below range.
   input wire logic [`SUB_COUNT-1:0][`SAMPLE_BITS-1:0] conv_data, // Raw offset binary result.
   input wire logic host_ready, // Host takes the sample this cycle.
   output logic [`SUB_COUNT-1:0] conv_start, // Start one conversion, pulse.
   output logic [`SUB_COUNT-1:0][2:0] conv_gain, // Gain code to converter.
   output logic [`SUB_COUNT-1:0][1:0] conv_range, // Range code to converter.
   output logic out_valid, // Sample offered to host.
   output logic [1:0] out_sub, // Subsystem of the sample.
   output logic out_single, // Sample answers a single request.
   output logic [`SAMPLE_BITS-1:0] out_data, // Coded sample word.
   output logic [`SUB_COUNT-1:0] stop_event, // Digital event stop done, pulse.
   output logic [`SUB_COUNT-1:0] overrun, // Sticky overrun flag.
   output logic [`SUB_COUNT-1:0] active // Subsystem not idle.
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned DIVW = 20;
   localparam int unsigned SW = `SAMPLE_BITS;

   // ---------------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------------
   typedef struct packed {
      logic [`LINE_COUNT-1:0] s1;
      logic [`LINE_COUNT-1:0] s2;
      logic [`LINE_COUNT-1:0] s3;
      logic armed;
      sub_state_t [`SUB_COUNT-1:0] st;
      logic [`SUB_COUNT-1:0][DIVW-1:0] div;
      logic [`SUB_COUNT-1:0] inflight;
      logic [`SUB_COUNT-1:0] single;
      logic [`SUB_COUNT-1:0][DEPTH-1:0][SW:0] mem;
      logic [`SUB_COUNT-1:0][PW-1:0] wp;
      logic [`SUB_COUNT-1:0][PW-1:0] rp;
      logic [`SUB_COUNT-1:0][PW:0] cnt;
      logic [`SUB_COUNT-1:0] conv_start;
      logic [`SUB_COUNT-1:0][2:0] gain;
      logic [`SUB_COUNT-1:0][1:0] range;
      logic out_valid;
      logic [1:0] out_sub;
      logic out_single;
      logic [SW-1:0] out_data;
      logic [`SUB_COUNT-1:0] stop_event;
      logic [`SUB_COUNT-1:0] overrun;
      logic [`SUB_COUNT-1:0] active;
   } ctl_state_t;

   ctl_state_t q;
   ctl_state_t d;

   timebase_if tb ();

   assign tb.mains_50hz = mains_50hz;

   timebase_gen #(
      .CORE_HZ(CORE_HZ)
   ) u_timebase (
      .core_clk(core_clk),
      .rst(rst),
      .tb(tb)
   );

   // ---------------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------------
   // Last time base count of a sample period; both modes need 5120 base ticks
   // at the top rate, so one table serves both and halving is a shift.
   function automatic logic [DIVW-1:0] pace_limit(input logic [2:0] rate);
      pace_limit = DIVW'((BASE_DIV << rate) - 1);
   endfunction

   // Range clamps win over coding so that out-of-range reads are unambiguous.
   function automatic logic [SW-1:0] code_sample(input logic [SW-1:0] raw,
                                                 input logic over,
                                                 input logic under,
                                                 input logic [1:0] rng);
      if (over) begin
         code_sample = `CODE_ONES;
      end else if (under) begin
         code_sample = `CODE_ZERO;
      end else if (rng == `RANGE_BIP) begin
         code_sample = raw ^ `CODE_SIGN;
      end else begin
         code_sample = raw;
      end
   endfunction

   function automatic logic [2:0] legal_gain(input logic [2:0] g);
      legal_gain = (g > `GAIN_MAX) ? `GAIN_MAX : g;
   endfunction

   // ---------------------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------------------
   always_comb begin
      logic found;
      logic [1:0] pop_n;
      logic fall_start;
      logic fall_stop;
      logic start_ok;
      logic tick;
      found = 1'b0;
      pop_n = 2'h0;
      fall_start = 1'b0;
      fall_stop = 1'b0;
      start_ok = 1'b0;
      tick = 1'b0;
      d = q;

      d.s1 = din_lines;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (&q.s2) begin
         d.armed = 1'b1;
      end
      d.conv_start = '0;
      d.stop_event = '0;

      // One shared output slot; lower subsystems that are not paused win when several have data.
      if (q.out_valid && host_ready) begin
         d.out_valid = 1'b0;
      end
      if (!q.out_valid || host_ready) begin
         for (int n = 0; n < `SUB_COUNT; n++) begin
            if (!found && q.cnt[n] != '0 && q.st[n] != SUB_PAUSED) begin
               found = 1'b1;
               pop_n = 2'(n);
            end
         end
      end
      if (found) begin
         d.out_valid = 1'b1;
         {d.out_single, d.out_data} = q.mem[pop_n][q.rp[pop_n]];
         d.out_sub = pop_n;
         d.rp[pop_n] = q.rp[pop_n] + 1'b1;
         d.cnt[pop_n] = q.cnt[pop_n] - 1'b1;
      end

      for (int n = 0; n < `SUB_COUNT; n++) begin
         fall_start = q.armed && q.s3[n] && !q.s2[n];
         fall_stop = q.armed && q.s3[n + `STOP_LINE_OFS]
                     && !q.s2[n + `STOP_LINE_OFS];
         start_ok = chan0_listed[n]
                    && ((trig_src[n] == `TRIG_SW && sw_start[n])
                        || (trig_src[n] != `TRIG_SW && fall_start));
         tick = 1'b0;

         if (overrun_clr[n]) begin
            d.overrun[n] = 1'b0;
         end

         unique case (q.st[n])
            SUB_IDLE: begin
               if (start_ok) begin
                  d.st[n] = SUB_RUN;
                  d.div[n] = '0;
                  d.gain[n] = legal_gain(gain_sel[n]);
                  d.range[n] = range_sel[n];
               end else if (single_req[n] && !q.inflight[n] && !conv_busy[n]) begin
                  d.conv_start[n] = 1'b1;
                  d.inflight[n] = 1'b1;
                  d.single[n] = 1'b1;
                  d.gain[n] = legal_gain(gain_sel[n]);
                  d.range[n] = range_sel[n];
               end
            end
            SUB_RUN: begin
               if (tb.tick) begin
                  if (q.div[n] >= pace_limit(rate_sel[n])) begin
                     d.div[n] = '0;
                     tick = 1'b1;
                  end else begin
                     d.div[n] = q.div[n] + 1'b1;
                  end
               end
               if (sw_stop[n]) begin
                  d.st[n] = SUB_FLUSH;
               end else if (trig_src[n] == `TRIG_EXT && fall_stop) begin
                  d.st[n] = SUB_PAUSED;
               end else if (trig_src[n] == `TRIG_DEV && fall_stop) begin
                  d.st[n] = SUB_FLUSH;
               end
            end
            SUB_PAUSED: begin
               if (sw_stop[n]) begin
                  d.st[n] = SUB_FLUSH;
               end else if (trig_src[n] == `TRIG_EXT && fall_start) begin
                  d.st[n] = SUB_RUN;
                  d.div[n] = '0;
               end
            end
            SUB_FLUSH: begin
               if (q.cnt[n] == '0 && !q.inflight[n]) begin
                  d.st[n] = SUB_IDLE;
                  d.stop_event[n] = (trig_src[n] == `TRIG_DEV);
               end
            end
         endcase

         // A pulse that finds the converter still at work is not queued.
         if (tick) begin
            if (q.inflight[n] || conv_busy[n]) begin
               d.overrun[n] = 1'b1;
            end else begin
               d.conv_start[n] = 1'b1;
               d.inflight[n] = 1'b1;
               d.single[n] = 1'b0;
            end
         end

         if (conv_done[n] && q.inflight[n]) begin
            d.inflight[n] = 1'b0;
            if (d.cnt[n] != (PW + 1)'(DEPTH)) begin
               d.mem[n][q.wp[n]] = {q.single[n],
                                    code_sample(conv_data[n], conv_over[n],
                                                conv_under[n], q.range[n])};
               d.wp[n] = q.wp[n] + 1'b1;
               d.cnt[n] = d.cnt[n] + 1'b1;
            end else begin
               d.overrun[n] = 1'b1;
            end
         end

         // Abrupt stop drops the buffered samples and any result still on its way; a sample already offered stays.
         if (sw_abort[n]) begin
            d.st[n] = SUB_IDLE;
            d.inflight[n] = 1'b0;
            d.conv_start[n] = 1'b0;
            d.wp[n] = '0;
            d.rp[n] = '0;
            d.cnt[n] = '0;
            if (found && pop_n == 2'(n)) begin
               d.out_valid = q.out_valid && !host_ready;
               {d.out_single, d.out_data} = {q.out_single, q.out_data};
               d.out_sub = q.out_sub;
            end
         end
         d.active[n] = (d.st[n] != SUB_IDLE);
      end
   end

   // ---------------------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         for (int n = 0; n < `SUB_COUNT; n++) begin
            q.st[n] <= SUB_IDLE;
            q.gain[n] <= `GAIN_RST;
            q.range[n] <= `RANGE_RST;
         end
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------------------
   assign conv_start = q.conv_start;
   assign conv_gain = q.gain;
   assign conv_range = q.range;
   assign out_valid = q.out_valid;
   assign out_sub = q.out_sub;
   assign out_single = q.out_single;
   assign out_data = q.out_data;
   assign stop_event = q.stop_event;
   assign overrun = q.overrun;
   assign active = q.active;
endmodule
`default_nettype wire

// ---- adc_trigger_pacing_control_props.sv ----
// Concurrent assertions on the ports of the trigger and pacing control.
`timescale 1ns/100ps
`default_nettype none
`include "pacing_consts.svh"
module adc_trigger_pacing_control_props
   import pacing_pkg::*;
#(
   parameter int unsigned BASE_DIV = 5120,
   parameter int unsigned DEPTH = 8,
   parameter int unsigned CORE_HZ = 10000000
) (
   input wire logic core_clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic [7:0] din_lines, // Pins.
   input wire logic [3:0][1:0] trig_src, // Source.
   input wire logic [3:0][2:0] gain_sel, // Gain.
   input wire logic [3:0] chan0_listed, // Listed.
   input wire logic [3:0] sw_start, // Start.
   input wire logic [3:0] overrun_clr, // Clear.
   input wire logic host_ready, // Taken.
   input wire logic [3:0] conv_start, // Convert.
   input wire logic [3:0][2:0] conv_gain, // Gain out.
   input wire logic [3:0][1:0] conv_range, // Range out.
   input wire logic out_valid, // Offered.
   input wire logic [1:0] out_sub, // Source.
   input wire logic out_single, // Single.
   input wire logic [23:0] out_data, // Word.
   input wire logic [3:0] stop_event, // Stopped.
   input wire logic [3:0] overrun, // Overrun.
   input wire logic [3:0] active // Running.
);
   logic [3:0] hi_cnt_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Edges are judged only well after all lines were high, past the arming delay.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hi_cnt_q <= 4'h0;
      end else if (hi_cnt_q != 4'h8 && (hi_cnt_q != 4'h0 || &din_lines)) begin
         hi_cnt_q <= hi_cnt_q + 4'h1;
      end
   end
   sequence s_sw_start(int k);
      sw_start[k] && trig_src[k] == `TRIG_SW && chan0_listed[k] && !active[k];
   endsequence
   sequence s_fall(int k);
      din_lines[k] ##1 !din_lines[k] [*4];
   endsequence
   property p_reset_vals;
      $fell(rst) |-> !out_valid && (active | overrun | stop_event | conv_start) == 4'h0
         && conv_gain == 12'h0 && conv_range == 8'haa;
   endproperty
   property p_hold;
      out_valid && !host_ready |=> out_valid && $stable(out_data) && $stable(out_sub)
         && $stable(out_single);
   endproperty
   property p_start(int k);
      s_sw_start(k) |=> active[k];
   endproperty
   property p_gain(int k);
      s_sw_start(k) |=> conv_gain[k] == ($past(gain_sel[k]) > 3'h6 ? 3'h6 : $past(gain_sel[k]));
   endproperty
   property p_refuse(int k);
      sw_start[k] && trig_src[k] == `TRIG_SW && !chan0_listed[k] && !active[k] |=> !active[k];
   endproperty
   property p_pin_start(int k);
      (hi_cnt_q == 4'h8 && trig_src[k] != `TRIG_SW && chan0_listed[k] && !active[k]) ##0
         s_fall(k) |-> ##[1:3] active[k];
   endproperty
   property p_ovr_hold(int k);
      overrun[k] && !overrun_clr[k] |=> overrun[k];
   endproperty
   property p_stop(int k);
      stop_event[k] |=> !stop_event[k] ##[0:1] !active[k];
   endproperty
   property p_pulse(int k);
      conv_start[k] |=> !conv_start[k];
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("Bad reset outputs");
   a_hold: assert property (p_hold) else $error("Sample changed while held");
   for (genvar k = 0; k < 4; k++) begin : g_sub
      a_start: assert property (p_start(k)) else $error("Start missed");
      a_gain: assert property (p_gain(k)) else $error("Gain not latched");
      a_refuse: assert property (p_refuse(k)) else $error("Unlisted start");
      a_pin_start: assert property (p_pin_start(k)) else $error("Pin start missed");
      a_ovr_hold: assert property (p_ovr_hold(k)) else $error("Overrun lost");
      a_stop: assert property (p_stop(k)) else $error("Stop event wrong");
      a_pulse: assert property (p_pulse(k)) else $error("Start pulse long");
   end
endmodule
bind adc_trigger_pacing_control adc_trigger_pacing_control_props #(
   .BASE_DIV(BASE_DIV), .DEPTH(DEPTH), .CORE_HZ(CORE_HZ)
) u_props (
   .core_clk, .rst, .din_lines, .trig_src, .gain_sel, .chan0_listed, .sw_start, .overrun_clr,
   .host_ready, .conv_start, .conv_gain, .conv_range, .out_valid, .out_sub, .out_single,
   .out_data, .stop_event, .overrun, .active
);
`default_nettype wire

// ---- adc_trigger_pacing_control_tb.sv ----
// Self-checking testbench of the trigger and pacing control.
`timescale 1ns/100ps
`default_nettype none
`include "pacing_consts.svh"
module adc_trigger_pacing_control_tb;
   localparam int BDIV = 4;
   logic core_clk, rst, mains_50hz, host_ready, out_valid, out_single;
   logic [7:0] din_lines;
   logic [3:0][1:0] trig_src, range_sel, conv_range;
   logic [3:0][2:0] gain_sel, rate_sel, conv_gain;
   logic [3:0] chan0_listed, sw_start, sw_stop, sw_abort, single_req, overrun_clr, single_exp;
   logic [3:0] conv_busy, conv_done, conv_over, conv_under, conv_start, over_in, under_in;
   logic [3:0] stop_event, overrun, active;
   logic [3:0][23:0] conv_data, raw;
   logic [3:0][7:0] lat;
   logic [1:0] out_sub;
   logic [23:0] out_data;
   logic [24:0] exp_q[4][$];
   longint tm;
   int err_count, checks_done, cyc, n, t0;
   int seed = 32'h36f6253d;
   adc_trigger_pacing_control #(.BASE_DIV(BDIV)) dut (
      .core_clk, .rst, .din_lines, .mains_50hz, .trig_src, .gain_sel, .range_sel, .rate_sel,
      .chan0_listed, .sw_start, .sw_stop, .sw_abort, .single_req, .overrun_clr, .conv_busy,
      .conv_done, .conv_over, .conv_under, .conv_data, .host_ready, .conv_start, .conv_gain,
      .conv_range, .out_valid, .out_sub, .out_single, .out_data, .stop_event, .overrun, .active);
   adc_conv_model u_conv (.core_clk, .rst, .conv_start, .lat, .raw, .over_in, .under_in,
      .conv_busy, .conv_done, .conv_over, .conv_under, .conv_data);
   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("Checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic pulse(ref logic [3:0] sig, input int s);
      sig[s] = 1'b1;
      @(negedge core_clk);
      sig[s] = 1'b0;
   endtask
   task automatic pin_fall(input int l);
      din_lines[l] = 1'b0;
      repeat (8) @(negedge core_clk);
      din_lines[l] = 1'b1;
      repeat (2) @(negedge core_clk);
   endtask
   task automatic wait_start(input int s);
      n = 0;
      while (conv_start[s] !== 1'b1 && n < 3000) begin @(negedge core_clk); n++; end
      @(negedge core_clk);
      check_val("conv_start seen", 1, n < 3000);
   endtask
   task automatic wait_idle(input int s);
      n = 0;
      while (active[s] !== 1'b0 && n < 500) begin @(negedge core_clk); n++; end
      check_val("idle", 1, n < 500);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(negedge core_clk) host_ready <= 1'($random(seed));
   // Each finished conversion is noted with the word the host must see for it.
   always @(posedge core_clk) begin
      cyc++;
      for (int s = 0; s < 4; s++) begin
         if (conv_done[s] === 1'b1) exp_q[s].push_back({single_exp[s], over_in[s] ? 24'hffffff
            : under_in[s] ? 24'h0 : raw[s] ^ (range_sel[s] == `RANGE_BIP ? 24'h800000 : 24'h0)});
      end
      if (out_valid === 1'b1 && host_ready) begin
         if (exp_q[out_sub].size() == 0) check_val("sample", 'x, {out_single, out_data});
         else check_val("sample", exp_q[out_sub].pop_front(), {out_single, out_data});
      end
      if (cyc == 60000) begin err_count++; complete_run(); end
   end
   initial begin
      {din_lines, mains_50hz, trig_src, range_sel, gain_sel, rate_sel} = '0;
      {sw_start, sw_stop, sw_abort, single_req, overrun_clr, over_in, under_in} = '0;
      {raw, single_exp} = '0;
      chan0_listed = 4'hf;
      lat = {4{8'h3}};
      rst = 1'b1;
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      check_val("conv_range", 32'haa, conv_range);
      for (int k = 0; k < 8; k++) begin
         {gain_sel[k % 4], range_sel[k % 4], raw[k % 4]} = {3'(k), 2'(k % 3), 24'($random(seed))};
         {over_in[k % 4], under_in[k % 4], single_exp[k % 4]} = {k == 6, k == 7, 1'b1};
         pulse(single_req, k % 4);
         wait_start(k % 4);
         check_val("conv_gain", k > 6 ? 6 : k, conv_gain[k % 4]);
         check_val("conv_range", k % 3, conv_range[k % 4]);
         repeat (12) @(negedge core_clk);
      end
      {over_in, under_in, single_exp} = '0;
      trig_src = {`TRIG_SW, `TRIG_DEV, `TRIG_EXT, `TRIG_SW};
      chan0_listed[3] = 1'b0;
      pulse(sw_start, 3);
      repeat (3) @(negedge core_clk);
      check_val("unlisted start", 0, active[3]);
      chan0_listed[3] = 1'b1;
      din_lines = 8'h02;
      repeat (4) @(negedge core_clk);
      pin_fall(1);
      check_val("early edge", 0, active[1]);
      din_lines = 8'hff;
      repeat (10) @(negedge core_clk);
      pin_fall(1);
      check_val("ext start", 1, active[1]);
      repeat (30) @(negedge core_clk);
      pin_fall(5);
      t0 = 0;
      repeat (40) begin @(negedge core_clk); t0 += int'(conv_start[1]); end
      check_val("paused starts", 0, t0);
      check_val("paused active", 1, active[1]);
      pin_fall(1);
      wait_start(1);
      rate_sel[1] = 3'h7;
      repeat (30) @(negedge core_clk);
      pulse(sw_stop, 1);
      wait_idle(1);
      pin_fall(2);
      check_val("event start", 1, active[2]);
      repeat (30) @(negedge core_clk);
      rate_sel[2] = 3'h7;
      repeat (30) @(negedge core_clk);
      din_lines[6] = 1'b0;
      n = 0;
      while (stop_event[2] !== 1'b1 && n < 300) begin @(negedge core_clk); n++; end
      check_val("stop_event", 1, n < 300);
      din_lines[6] = 1'b1;
      repeat (20) @(negedge core_clk);
      check_val("flush left", 0, exp_q[2].size());
      check_val("event stop", 0, active[2]);
      for (int m = 0; m < 2; m++) begin
         for (int r = 0; r < 8; r += 7) begin
            {mains_50hz, rate_sel[3]} = {m[0], 3'(r)};
            pulse(sw_start, 3);
            wait_start(3);
            wait_start(3);
            tm = $time;
            wait_start(3);
            t0 = int'(($time - tm) / 100) - int'(64'd10000000 * (BDIV << r) / (m ? 4096000 : 4915200));
            check_val("pace gap", 1, t0 >= -2 && t0 <= 2);
            rate_sel[3] = 3'h7;
            repeat (10) @(negedge core_clk);
            pulse(sw_stop, 3);
            wait_idle(3);
         end
      end
      {mains_50hz, rate_sel[3], lat[3]} = {1'b0, 3'h0, 8'd40};
      pulse(sw_start, 3);
      repeat (60) @(negedge core_clk);
      check_val("overrun", 1, overrun[3]);
      {rate_sel[3], lat[3]} = {3'h7, 8'h3};
      repeat (60) @(negedge core_clk);
      pulse(sw_stop, 3);
      wait_idle(3);
      pulse(overrun_clr, 3);
      check_val("overrun cleared", 0, overrun[3]);
      repeat (100) @(negedge core_clk);
      check_val("pending", 0, exp_q[0].size() + exp_q[1].size() + exp_q[3].size());
      complete_run();
   end
endmodule
`default_nettype wire

// ---- pacing_consts.svh ----
// Constants for the trigger and pacing control of the four converter subsystems.
`ifndef PACING_CONSTS_SVH
`define PACING_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------------------
`define CORE_CLK_HZ 10000000
`define TB_60HZ_HZ 4915200
`define TB_50HZ_HZ 4096000
// Time base ticks per sample at the fastest rate (960 or 800 samples/s).
`define BASE_DIV 5120
`define RATE_CODES 8

// ----------------------------------------------------------------------------
// Subsystem layout
// ----------------------------------------------------------------------------
`define SUB_COUNT 4
`define LINE_COUNT 8
`define STOP_LINE_OFS 4
`define SAMPLE_BITS 24
`define BUF_DEPTH 8

// ----------------------------------------------------------------------------
// Field codes and reset values
// ----------------------------------------------------------------------------
`define TRIG_SW 2'h0
`define TRIG_EXT 2'h1
`define TRIG_DEV 2'h2
`define RANGE_UNI 2'h0
`define RANGE_OFS 2'h1
`define RANGE_BIP 2'h2
`define GAIN_MAX 3'h6
`define GAIN_RST 3'h0
`define RANGE_RST 2'h2
`define CODE_SIGN 24'h800000
`define CODE_ONES 24'hffffff
`define CODE_ZERO 24'h000000

`endif

// ---- pacing_pkg.sv ----
// Types shared by the trigger and pacing control modules.
`default_nettype none
package pacing_pkg;
   typedef enum logic [1:0] {SUB_IDLE, SUB_RUN, SUB_PAUSED, SUB_FLUSH} sub_state_t;
endpackage
`default_nettype wire

// ---- timebase_gen.sv ----
// Fractional generator of the 4.9152 MHz or 4.0960 MHz time base tick.
`timescale 1ns/100ps
`default_nettype none
`include "pacing_consts.svh"
module timebase_gen
   import pacing_pkg::*;
#(
   parameter int unsigned CORE_HZ = `CORE_CLK_HZ
) (
   input wire logic core_clk, // Core clock.
   input wire logic rst, // Asynchronous reset, active high.
   timebase_if.gen tb // Mode in, tick out.
);
   // ---------------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------------
   typedef struct packed {
      logic [24:0] acc;
      logic tick;
   } tb_state_t;

   tb_state_t q;
   tb_state_t d;

   // A phase accumulator keeps the long-run tick rate exact; single ticks jitter
   // by one core cycle, which the sample divider averages out.
   always_comb begin
      logic [24:0] sum;
      sum = '0;
      d = q;
      sum = q.acc + (tb.mains_50hz ? 25'(`TB_50HZ_HZ) : 25'(`TB_60HZ_HZ));
      d.tick = 1'b0;
      if (sum >= 25'(CORE_HZ)) begin
         d.acc = sum - 25'(CORE_HZ);
         d.tick = 1'b1;
      end else begin
         d.acc = sum;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tb.tick = q.tick;
endmodule
`default_nettype wire

// ---- timebase_if.sv ----
// Carrier between the control block and its shared time base generator.
`timescale 1ns/100ps
`default_nettype none
interface timebase_if;
   logic mains_50hz;
   logic tick;
   modport gen (input mains_50hz, output tick);
   modport user (output mains_50hz, input tick);
endinterface
`default_nettype wire
